// ==== verilog/dac_cmd_pkg.sv ====
// Shared constants and carrier types for the octal converter command decoder.
// Assumes a single 20 MHz system clock and a byte-level serial front end.
`default_nettype none

package dac_cmd_pkg;

    // ==========================================================
    // Geometry
    localparam int CHANNELS = 8;
    localparam int WORD_BITS = 16;
    localparam int RES_DEFAULT = 12;

    // ==========================================================
    // Command and access nibble values
    localparam logic [3:0] CMD_WRITE_INPUT = 4'h0;
    localparam logic [3:0] CMD_SELECT_UPDATE = 4'h1;
    localparam logic [3:0] ACC_BROADCAST = 4'hF;

    // ==========================================================
    // Reset and mask values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] MASK_ALL = 8'hFF;

    // ==========================================================
    // Frame phases
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_CA = 3'b001,
        PH_HI = 3'b010,
        PH_LO = 3'b011,
        PH_ACK = 3'b100,
        PH_RD = 3'b101
    } phase_t;

    // One write frame after the address byte
    typedef struct packed {
        logic [3:0] command;
        logic [3:0] access;
        logic [7:0] high_data_byte;
        logic [7:0] low_data_byte;
    } frame_t;

    // Access nibble decode result
    typedef struct packed {
        logic valid;
        logic [7:0] mask;
    } select_t;

endpackage : dac_cmd_pkg

`default_nettype wire

// ==== verilog/dac_cmd_decoder.sv ====
// Command decoder for an eight-channel voltage-output converter.
// Assumes a byte-level two-wire slave engine on the same clock that matches
// the slave address and reports bytes, starts and acknowledge edges.
//
// What this block does
// (RL1) 8-bit: high byte is code, low ignored
// (RL2) 10-bit: high byte D9..D2, low top two
// (RL3) 12-bit: high byte D11..D4, low nibble
// (RL4) Frame: command/access byte, then sixteen left-justified bits
// (RL5) Cmd 0, access 0..7 writes one input
// (RL6) Cmd 0, access 8..14 invalid, nothing changes
// (RL7) Cmd 0, access 15 writes all inputs
// (RL8) Cmd 1 copies input to output register
// (RL9) Master still sends both data bytes
// (RL10) Read returns high byte then low byte
// (RL11) Effect applied at acknowledge after low byte
// (RL12) Upper nibble command, lower nibble access
// (RL13) Outputs hold until an update names them
`default_nettype none

module dac_cmd_decoder
    import dac_cmd_pkg::*;
#(
    parameter int RES = RES_DEFAULT
) (
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic FRAME_START_IN,
    input wire logic FRAME_READ_IN,
    input wire logic RX_VALID_IN,
    input wire logic [7:0] RX_BYTE_IN,
    input wire logic ACK_FALL_IN,
    input wire logic TX_REQ_IN,
    output logic [7:0] TX_BYTE_OUT,
    output logic TX_VALID_OUT,
    output logic [CHANNELS*RES-1:0] CODE_OUT,
    output logic [7:0] LOAD_PULSE_OUT,
    output logic INVALID_OUT
);

    // ==========================================================
    // Access decode, shared by the write and update paths
    function automatic select_t decode_access(input logic [3:0] acc);
        select_t s;
        s.valid = 1'b0;
        s.mask = MASK_NONE;
        if (acc == ACC_BROADCAST) begin
            s.valid = 1'b1;
            s.mask = MASK_ALL;
        end else if (!acc[3]) begin
            s.valid = 1'b1;
            s.mask = MASK_NONE;
            s.mask[acc[2:0]] = 1'b1;
        end
        return s;
    endfunction : decode_access

    // Left-justify a code into the sixteen-bit data field
    function automatic logic [WORD_BITS-1:0] justify(input logic [RES-1:0] c);
        return {c, {(WORD_BITS-RES){1'b0}}};
    endfunction : justify

    // ==========================================================
    // State
    phase_t ph_q, ph_d;
    frame_t fr_q, fr_d;
    logic rd_idx_q, rd_idx_d;
    logic [RES-1:0] in_q [CHANNELS];
    logic [RES-1:0] in_d [CHANNELS];
    logic [RES-1:0] out_q [CHANNELS];
    logic [RES-1:0] out_d [CHANNELS];
    logic [7:0] tx_q, tx_d;
    logic tx_v_q, tx_v_d;
    logic [7:0] load_q, load_d;
    logic inv_q, inv_d;

    // Code taken from the left-justified field; low don't-care bits drop
    logic [WORD_BITS-1:0] rx_word;
    logic [RES-1:0] rx_code;
    assign rx_word = {fr_q.high_data_byte, fr_q.low_data_byte}; // RL4
    assign rx_code = rx_word[WORD_BITS-1 -: RES]; // RL1 RL2 RL3

    // ==========================================================
    // Frame sequencing and register effects
    always_comb begin
        select_t sel;
        logic [WORD_BITS-1:0] rd_word;
        sel = decode_access(fr_q.access); // RL12
        rd_word = '0;
        ph_d = ph_q;
        fr_d = fr_q;
        rd_idx_d = rd_idx_q;
        in_d = in_q;
        out_d = out_q; // RL13
        tx_d = tx_q;
        tx_v_d = 1'b0;
        load_d = MASK_NONE;
        inv_d = 1'b0;

        if (fr_q.command == CMD_WRITE_INPUT && !fr_q.access[3]) begin
            rd_word = justify(in_q[fr_q.access[2:0]]);
        end else if (fr_q.command == CMD_SELECT_UPDATE
                     && !fr_q.access[3]) begin
            rd_word = justify(out_q[fr_q.access[2:0]]);
        end

        if (FRAME_START_IN) begin
            // A start always restarts framing; a frame cut short has no effect
            ph_d = FRAME_READ_IN ? PH_RD : PH_CA;
            rd_idx_d = 1'b0;
        end else begin
            case (ph_q)
                PH_CA: begin
                    if (RX_VALID_IN) begin
                        fr_d.command = RX_BYTE_IN[7:4]; // RL12
                        fr_d.access = RX_BYTE_IN[3:0]; // RL12
                        ph_d = PH_HI;
                    end
                end
                PH_HI: begin
                    if (RX_VALID_IN) begin
                        fr_d.high_data_byte = RX_BYTE_IN; // RL4
                        ph_d = PH_LO;
                    end
                end
                PH_LO: begin
                    if (RX_VALID_IN) begin
                        fr_d.low_data_byte = RX_BYTE_IN; // RL4 RL9
                        ph_d = PH_ACK;
                    end
                end
                PH_ACK: begin
                    if (ACK_FALL_IN) begin // RL11
                        ph_d = PH_IDLE;
                        case (fr_q.command)
                            CMD_WRITE_INPUT: begin
                                if (sel.valid) begin
                                    for (int i = 0; i < CHANNELS; i++) begin
                                        if (sel.mask[i]) begin
                                            in_d[i] = rx_code; // RL5 RL7
                                        end
                                    end
                                end else begin
                                    inv_d = 1'b1; // RL6
                                end
                            end
                            CMD_SELECT_UPDATE: begin
                                // Data bytes were taken but are not used
                                if (sel.valid) begin
                                    for (int i = 0; i < CHANNELS; i++) begin
                                        if (sel.mask[i]) begin
                                            out_d[i] = in_q[i]; // RL8
                                        end
                                    end
                                    load_d = sel.mask; // RL8
                                end else begin
                                    inv_d = 1'b1;
                                end
                            end
                            default: begin
                                // Other commands are not handled here
                                ph_d = PH_IDLE;
                            end
                        endcase
                    end
                end
                PH_RD: begin
                    if (TX_REQ_IN) begin
                        // High byte first, low byte on every later request
                        tx_d = rd_idx_q ? rd_word[7:0]
                                        : rd_word[15:8]; // RL10
                        tx_v_d = 1'b1;
                        rd_idx_d = 1'b1; // RL10
                    end
                end
                default: begin
                    ph_d = PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESETN_IN) begin
            ph_q <= PH_IDLE;
            fr_q <= '0;
            rd_idx_q <= 1'b0;
            for (int i = 0; i < CHANNELS; i++) begin
                in_q[i] <= '0;
                out_q[i] <= '0;
            end
            tx_q <= BYTE_RESET;
            tx_v_q <= 1'b0;
            load_q <= MASK_NONE;
            inv_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            fr_q <= fr_d;
            rd_idx_q <= rd_idx_d;
            in_q <= in_d;
            out_q <= out_d;
            tx_q <= tx_d;
            tx_v_q <= tx_v_d;
            load_q <= load_d;
            inv_q <= inv_d;
        end
    end

    // ==========================================================
    // Outputs
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_code
            assign CODE_OUT[g*RES +: RES] = out_q[g];
        end
    endgenerate

    assign TX_BYTE_OUT = tx_q;
    assign TX_VALID_OUT = tx_v_q;
    assign LOAD_PULSE_OUT = load_q;
    assign INVALID_OUT = inv_q;

endmodule : dac_cmd_decoder

`default_nettype wire

// ==== bench/dac_cmd_props.sv ====
// Port checker for the converter command decoder.
// Assumes a bind into every decoder instance.
`default_nettype none
module dac_cmd_props
    import dac_cmd_pkg::*;
#(parameter int RES = RES_DEFAULT) (
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic ACK_FALL_IN,
    input wire logic TX_REQ_IN,
    input wire logic [7:0] TX_BYTE_OUT,
    input wire logic TX_VALID_OUT,
    input wire logic [CHANNELS*RES-1:0] CODE_OUT,
    input wire logic [7:0] LOAD_PULSE_OUT,
    input wire logic INVALID_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    load_cause_a: assert property (|LOAD_PULSE_OUT |->
        $past(ACK_FALL_IN)) else $error("load cause");
    bad_cause_a: assert property (INVALID_OUT |->
        $past(ACK_FALL_IN)) else $error("invalid cause");
    load_shape_a: assert property (|LOAD_PULSE_OUT |->
        $onehot(LOAD_PULSE_OUT) || &LOAD_PULSE_OUT) else $error("mask");
    bad_quiet_a: assert property (INVALID_OUT |->
        !LOAD_PULSE_OUT && $stable(CODE_OUT)) else $error("invalid acted");
    code_hold_a: assert property (!$stable(CODE_OUT) |->
        |LOAD_PULSE_OUT) else $error("code moved");
    load_once_a: assert property (|LOAD_PULSE_OUT |=>
        !LOAD_PULSE_OUT) else $error("load held");
    tx_cause_a: assert property (TX_VALID_OUT |->
        $past(TX_REQ_IN)) else $error("byte cause");
    tx_hold_a: assert property (!TX_VALID_OUT |->
        $stable(TX_BYTE_OUT)) else $error("byte moved");
endmodule : dac_cmd_props
bind dac_cmd_decoder dac_cmd_props #(.RES(RES)) dac_cmd_props_i (
    .SYS_CLK_IN(SYS_CLK_IN),
    .RESETN_IN(RESETN_IN),
    .ACK_FALL_IN(ACK_FALL_IN),
    .TX_REQ_IN(TX_REQ_IN),
    .TX_BYTE_OUT(TX_BYTE_OUT),
    .TX_VALID_OUT(TX_VALID_OUT),
    .CODE_OUT(CODE_OUT),
    .LOAD_PULSE_OUT(LOAD_PULSE_OUT),
    .INVALID_OUT(INVALID_OUT)
);
`default_nettype wire

// ==== bench/link_master.sv ====
// Byte-level link master in place of the serial front end.
// Assumes one clock; each pulse lasts one cycle, then one idle cycle.
`default_nettype none
module link_master (
    input wire logic clk_in,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_byte_in,
    output logic [4:0] ctl_out,
    output logic [7:0] byte_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {ctl_out, byte_out} = 13'h005A;
    task automatic put(input logic [4:0] c, input logic [7:0] b);
        @(posedge clk_in);
        ctl_out <= c;
        byte_out <= b;
        @(posedge clk_in);
        ctl_out <= 5'h00;
        byte_out <= ~b; // Released lines never keep the last byte
    endtask : put
    task automatic write(input logic [7:0] ca, hi, lo);
        put(5'h10, ca);
        put(5'h04, ca);
        put(5'h04, hi);
        put(5'h04, lo);
        put(5'h02, hi);
    endtask : write
    task automatic read(input logic [7:0] ca, output logic [15:0] v);
        put(5'h10, ca);
        put(5'h04, ca);
        put(5'h18, ca);
        for (int k = 1; k >= 0; k--) begin
            put(5'h01, ca);
            @(negedge clk_in);
            v[k*8 +: 8] = tx_valid_in ? tx_byte_in : 8'hXX;
        end
    endtask : read
endmodule : link_master
`default_nettype wire

// ==== bench/dac_cmd_decoder_test.sv ====
// Bench: one decoder behind a byte-level link master.
// Assumes package, decoder, master and checker compile first.
`default_nettype none
module dac_cmd_decoder_test;
    import dac_cmd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic SYS_CLK_IN = 1'b0, RESETN_IN = 1'b0;
    wire logic FRAME_START_IN, FRAME_READ_IN, RX_VALID_IN, ACK_FALL_IN;
    wire logic TX_REQ_IN;
    wire logic [7:0] RX_BYTE_IN;
    logic TX_VALID_OUT, INVALID_OUT;
    logic [7:0] TX_BYTE_OUT, LOAD_PULSE_OUT;
    logic [CHANNELS*12-1:0] CODE_OUT;
    int failures = 0, checks_done = 0;
    always #25 SYS_CLK_IN = ~SYS_CLK_IN;
    link_master link_master_i (.clk_in(SYS_CLK_IN),
        .tx_valid_in(TX_VALID_OUT), .tx_byte_in(TX_BYTE_OUT),
        .ctl_out({FRAME_START_IN, FRAME_READ_IN, RX_VALID_IN, ACK_FALL_IN,
        TX_REQ_IN}), .byte_out(RX_BYTE_IN));
    dac_cmd_decoder dac_cmd_decoder_i (
        .SYS_CLK_IN(SYS_CLK_IN),
        .RESETN_IN(RESETN_IN),
        .FRAME_START_IN(FRAME_START_IN),
        .FRAME_READ_IN(FRAME_READ_IN),
        .RX_VALID_IN(RX_VALID_IN),
        .RX_BYTE_IN(RX_BYTE_IN),
        .ACK_FALL_IN(ACK_FALL_IN),
        .TX_REQ_IN(TX_REQ_IN),
        .TX_BYTE_OUT(TX_BYTE_OUT),
        .TX_VALID_OUT(TX_VALID_OUT),
        .CODE_OUT(CODE_OUT),
        .LOAD_PULSE_OUT(LOAD_PULSE_OUT),
        .INVALID_OUT(INVALID_OUT)
    );
    task automatic cmp(input string s, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) $display("Error %s expected %h seen %h", s, e, g);
        if (g !== e) failures++;
    endtask : cmp
    task automatic conclude;
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic t_channels;
        for (int n = 0; n < CHANNELS; n++) begin
            link_master_i.write(8'(n), 8'(16 + n), 8'h5F);
            link_master_i.write(8'(16 + n), 8'hEE, 8'hEE);
            @(negedge SYS_CLK_IN);
            cmp("load", 16'(1 << n), 16'(LOAD_PULSE_OUT));
            cmp("code", 16'(261 + 16 * n), 16'(CODE_OUT[n*12 +: 12]));
        end
    endtask : t_channels
    task automatic t_misc;
        logic [15:0] v;
        link_master_i.read(8'h13, v);
        cmp("read", 16'h1350, v);
        link_master_i.write(8'h0F, 8'hA5, 8'hF3);
        @(negedge SYS_CLK_IN);
        cmp("hold", 16'h0175, 16'(CODE_OUT[95:84]));
        link_master_i.read(8'h05, v);
        cmp("read input", 16'hA5F0, v);
        for (int a = 8; a < 15; a++) begin
            link_master_i.write(8'(a), 8'h11, 8'h11);
            @(negedge SYS_CLK_IN);
            cmp("invalid", 16'h0001, 16'(INVALID_OUT));
            link_master_i.write(8'(16 + a), 8'h11, 8'h11);
            @(negedge SYS_CLK_IN);
            cmp("invalid update", 16'h0001, 16'(INVALID_OUT));
        end
        link_master_i.write(8'h23, 8'h11, 8'h11);
        @(negedge SYS_CLK_IN);
        cmp("other", 16'h0000, 16'({LOAD_PULSE_OUT, INVALID_OUT}));
        link_master_i.write(8'h1F, 8'h00, 8'h00);
        @(negedge SYS_CLK_IN);
        cmp("load all", 16'h00FF, 16'(LOAD_PULSE_OUT));
        cmp("all", 16'h0A5F, 16'(CODE_OUT[95:84]));
    endtask : t_misc
    initial begin
        repeat (5) @(posedge SYS_CLK_IN);
        RESETN_IN <= 1'b1;
        t_channels();
        t_misc();
        conclude();
    end
endmodule : dac_cmd_decoder_test
`default_nettype wire
